// ==== verilog/pmbcr_pkg.sv ====
// Package: command codes, register slots, reset values and types of the command register bank
package pmbcr_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h40; // Bus address, arbitrary value
  // ==================================================
  // Command codes
  localparam logic [7:0] CMD_RUN_MARGIN = 8'h01;
  localparam logic [7:0] CMD_TURN_ON    = 8'h02;
  localparam logic [7:0] CMD_CLEAR      = 8'h03;
  localparam logic [7:0] CMD_WLOCK      = 8'h10;
  localparam logic [7:0] CMD_STORE      = 8'h15;
  localparam logic [7:0] CMD_RESTORE    = 8'h16;
  localparam logic [7:0] CMD_FEATURES   = 8'h19;
  localparam logic [7:0] CMD_ALERT_MASK = 8'h1b;
  localparam logic [7:0] CMD_SETPOINT   = 8'h21;
  localparam logic [7:0] CMD_FINE_ADJ   = 8'h22;
  localparam logic [7:0] CMD_CEILING    = 8'h24;
  localparam logic [7:0] CMD_UPPER      = 8'h25;
  localparam logic [7:0] CMD_LOWER      = 8'h26;
  localparam logic [7:0] CMD_SLEW       = 8'h27;
  localparam logic [7:0] CMD_DIVIDER    = 8'h29;
  localparam logic [7:0] CMD_SW_RATE    = 8'h33;
  localparam logic [7:0] CMD_VIN_START  = 8'h35;
  localparam logic [7:0] CMD_VIN_STOP   = 8'h36;
  localparam logic [7:0] CMD_CS_OFFSET  = 8'h39;
  localparam logic [7:0] CMD_OV_FAULT   = 8'h40;
  localparam logic [7:0] CMD_OV_REACT   = 8'h41;
  localparam logic [7:0] CMD_OV_WARN    = 8'h42;
  // ==================================================
  // Storage slots
  localparam int         NSLOT = 18;
  localparam logic [4:0] SL_RUN = 5'h00, SL_TURN_ON = 5'h01, SL_WLOCK = 5'h02;
  localparam logic [4:0] SL_MASK = 5'h03, SL_SETPOINT = 5'h04, SL_FINE = 5'h05;
  localparam logic [4:0] SL_CEIL = 5'h06, SL_UPPER = 5'h07, SL_LOWER = 5'h08;
  localparam logic [4:0] SL_SLEW = 5'h09, SL_DIV = 5'h0a, SL_SWR = 5'h0b;
  localparam logic [4:0] SL_VSTART = 5'h0c, SL_VSTOP = 5'h0d, SL_CSOFF = 5'h0e;
  localparam logic [4:0] SL_OVF = 5'h0f, SL_OVREACT = 5'h10, SL_OVW = 5'h11;
  localparam logic [4:0] SL_NONE = 5'h1f;
  // Reset values; output voltages in 1 mV codes, byte-wide control registers as bit fields, others linear exponent/mantissa
  localparam logic [15:0] SLOT_RESET [0:NSLOT-1] = '{
    16'h0080, 16'h0016, 16'h0000, 16'h0000, 16'h03e8, 16'h0000,
    16'h07d0, 16'h041a, 16'h03b6, 16'he801, 16'he808, 16'h03d2,
    16'hf810, 16'hf80e, 16'hf000, 16'h0576, 16'h0080, 16'h0515};
  // ==================================================
  // Field positions and fixed values
  localparam logic [7:0] FEATURE_VALUE = 8'hb0;
  localparam logic [7:0] BLOCK_COUNT   = 8'h02;
  localparam logic [7:0] EMPTY_BYTE    = 8'hff;
  localparam logic [7:0] WL_ALL        = 8'h80;
  localparam logic [7:0] WL_RUN        = 8'h40;
  localparam logic [7:0] WL_SET        = 8'h20;
  localparam logic [4:0] EXP_DIV       = 5'h1d;
  localparam logic [4:0] EXP_SLEW_MIN  = 5'h1c;
  localparam logic [4:0] EXP_ONE       = 5'h01;
  localparam int         RUN_ON_BIT    = 7;
  localparam int         MARGIN_LSB    = 4;
  localparam int         CFG_USE_BIT   = 4;
  localparam int         CFG_CMD_BIT   = 3;
  localparam int         CFG_PIN_BIT   = 2;
  localparam int         CFG_POL_BIT   = 1;
  localparam int         OV_SHUT_BIT   = 7;
  localparam logic [3:0] BIT_LAST      = 4'h7;
  localparam logic [3:0] BIT_ACK       = 4'h8;
  // ==================================================
  // Types
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001, ST_ADDR = 6'b000010, ST_CMD = 6'b000100,
    ST_WR   = 6'b001000, ST_RD   = 6'b010000, ST_IGN = 6'b100000
  } pmbcr_state_t;
  typedef struct packed {
    logic        out_on;
    logic [15:0] vout_mv;
    logic [15:0] alert_mask;
    logic [15:0] slew;
    logic [15:0] divider;
    logic [15:0] sw_rate;
    logic [15:0] vin_start;
    logic [15:0] vin_stop;
    logic [15:0] cs_offset;
    logic [15:0] ov_fault;
    logic [15:0] ov_warn;
    logic        ov_shutdown;
  } pmbcr_cfg_t;
endpackage

// ==== verilog/pmbcr_bank.sv ====
// Command register bank behind a two-wire serial link, with shadow nonvolatile copy
`timescale 1ns/10ps
`default_nettype none
module pmbcr_bank (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 scl,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  input  wire logic                 enable_pin,
  output pmbcr_pkg::pmbcr_cfg_t     cfg,
  output logic                      fault_clear,
  output logic                      otp_burn
);
  import pmbcr_pkg::*;

  // ==================================================
  // Decode functions
  function automatic logic [4:0] cmd_slot(input logic [7:0] c);
    if (c == CMD_RUN_MARGIN) cmd_slot = SL_RUN;
    else if (c == CMD_TURN_ON) cmd_slot = SL_TURN_ON;
    else if (c == CMD_WLOCK) cmd_slot = SL_WLOCK;
    else if (c == CMD_ALERT_MASK) cmd_slot = SL_MASK;
    else if (c == CMD_SETPOINT) cmd_slot = SL_SETPOINT;
    else if (c == CMD_FINE_ADJ) cmd_slot = SL_FINE;
    else if (c == CMD_CEILING) cmd_slot = SL_CEIL;
    else if (c == CMD_UPPER) cmd_slot = SL_UPPER;
    else if (c == CMD_LOWER) cmd_slot = SL_LOWER;
    else if (c == CMD_SLEW) cmd_slot = SL_SLEW;
    else if (c == CMD_DIVIDER) cmd_slot = SL_DIV;
    else if (c == CMD_SW_RATE) cmd_slot = SL_SWR;
    else if (c == CMD_VIN_START) cmd_slot = SL_VSTART;
    else if (c == CMD_VIN_STOP) cmd_slot = SL_VSTOP;
    else if (c == CMD_CS_OFFSET) cmd_slot = SL_CSOFF;
    else if (c == CMD_OV_FAULT) cmd_slot = SL_OVF;
    else if (c == CMD_OV_REACT) cmd_slot = SL_OVREACT;
    else if (c == CMD_OV_WARN) cmd_slot = SL_OVW;
    else cmd_slot = SL_NONE;
  endfunction

  // Byte-wide registers take one data byte, all others a word
  function automatic logic is_word(input logic [4:0] s);
    is_word = !(s == SL_RUN || s == SL_TURN_ON || s == SL_WLOCK || s == SL_OVREACT);
  endfunction

  // Lock level decides which commands still change state
  function automatic logic lock_allows(input logic [7:0] c, input logic [7:0] wl);
    if (wl == WL_ALL) lock_allows = (c == CMD_WLOCK);
    else if (wl == WL_RUN) lock_allows = (c == CMD_WLOCK || c == CMD_RUN_MARGIN);
    else if (wl == WL_SET)
      lock_allows = (c == CMD_WLOCK || c == CMD_RUN_MARGIN || c == CMD_TURN_ON ||
                     c == CMD_SETPOINT);
    else lock_allows = 1'b1;
  endfunction

  // Exponent and value checks; rejected words leave the register unchanged
  function automatic logic value_ok(input logic [4:0] s, input logic [15:0] d);
    if (s == SL_SLEW) value_ok = (d[15:11] == 5'h00) || (d[15:11] >= EXP_SLEW_MIN);
    else if (s == SL_DIV)
      value_ok = (d[15:11] == EXP_DIV) && (d[10:0] == 11'h008 || d[10:0] == 11'h004 ||
                 d[10:0] == 11'h002 || d[10:0] == 11'h001);
    else if (s == SL_SWR) value_ok = (d[15:11] == 5'h00) || (d[15:11] == EXP_ONE);
    else value_ok = 1'b1;
  endfunction

  // ==================================================
  // Link domain: data bits are shifted on the serial clock itself
  logic [7:0] rx_shift_r;
  // Shift is stable from one rising edge to the next, which the core samples
  always_ff @(posedge scl) begin
    rx_shift_r <= {rx_shift_r[6:0], sda_in};
  end

  // ==================================================
  // Synchronisers into the core clock
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, en_m, en_s;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      {scl_m, scl_s, scl_d} <= 3'b111;
      {sda_m, sda_s, sda_d} <= 3'b111;
      {en_m, en_s}          <= 2'b00;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
      {en_m, en_s}          <= {enable_pin, en_m};
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  // Start and stop are data edges while the clock is high
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;

  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

  // ==================================================
  // Bit counter: 0..7 data, 8 acknowledge
  logic [3:0] bit_cnt_r;
  logic       byte_done;
  always_ff @(posedge ref_clk) begin
    if (reset || start_det) bit_cnt_r <= 4'h0;
    else if (scl_rise) bit_cnt_r <= (bit_cnt_r == BIT_ACK) ? 4'h0 : bit_cnt_r + 4'h1;
  end
  assign byte_done = scl_rise && (bit_cnt_r == BIT_LAST);

  // ==================================================
  // Register storage and shadow nonvolatile copy
  logic [15:0]  regs_r [0:NSLOT-1];
  logic [15:0]  otp_r  [0:NSLOT-1];
  logic         commit_r, clear_p_r, store_p_r, restore_p_r;
  logic [4:0]   commit_slot_r;
  logic [15:0]  commit_data_r;

  genvar g;
  generate
    for (g = 0; g < NSLOT; g++) begin : g_slot
      // Working copy: restore wins over a write landing in the same cycle
      always_ff @(posedge ref_clk) begin
        if (reset) regs_r[g] <= SLOT_RESET[g];
        else if (restore_p_r) regs_r[g] <= otp_r[g];
        else if (commit_r && commit_slot_r == 5'(g)) regs_r[g] <= commit_data_r;
      end

      // Nonvolatile image; modelled in flops, burn pulse also leaves the block
      always_ff @(posedge ref_clk) begin
        if (reset) otp_r[g] <= SLOT_RESET[g];
        else if (store_p_r) otp_r[g] <= regs_r[g];
      end
    end
  endgenerate

  // ==================================================
  // Transaction state
  pmbcr_state_t state_r;
  logic [7:0]   cmd_r, wr_lo_r;
  logic         have_cmd_r, ack_r;
  logic [1:0]   wr_cnt_r, tx_idx_r;
  logic [4:0]   cur_slot, rx_slot;
  logic [7:0]   rx_byte, tx_byte;
  logic [15:0]  wr_word;
  logic         writable, last_byte, known_cmd;

  assign rx_byte   = rx_shift_r;
  assign cur_slot  = cmd_slot(cmd_r);
  assign rx_slot   = cmd_slot(rx_byte);
  assign writable  = (cur_slot != SL_NONE) && lock_allows(cmd_r, regs_r[SL_WLOCK][7:0]);
  assign last_byte = is_word(cur_slot) ? (wr_cnt_r == 2'd1) : (wr_cnt_r == 2'd0);
  // Low byte arrives first
  assign wr_word   = is_word(cur_slot) ? {rx_byte, wr_lo_r} : {8'h00, rx_byte};
  // Send-byte and read-only codes still take the command byte
  assign known_cmd = (rx_slot != SL_NONE) || rx_byte == CMD_CLEAR || rx_byte == CMD_STORE ||
                     rx_byte == CMD_RESTORE || rx_byte == CMD_FEATURES;

  // Command sequencing; data writes are committed on the closing byte
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r       <= ST_IDLE;
      cmd_r         <= 8'h00;
      wr_lo_r       <= 8'h00;
      have_cmd_r    <= 1'b0;
      ack_r         <= 1'b0;
      wr_cnt_r      <= 2'd0;
      tx_idx_r      <= 2'd0;
      commit_r      <= 1'b0;
      commit_slot_r <= SL_NONE;
      commit_data_r <= 16'h0000;
      clear_p_r     <= 1'b0;
      store_p_r     <= 1'b0;
      restore_p_r   <= 1'b0;
    end else begin
      commit_r    <= 1'b0;
      clear_p_r   <= 1'b0;
      store_p_r   <= 1'b0;
      restore_p_r <= 1'b0;

      if (start_det) begin
        state_r <= ST_ADDR;
        ack_r   <= 1'b0;
      end else if (stop_det) begin
        // Send byte: a command with no data ends in stop
        if (state_r == ST_WR && wr_cnt_r == 2'd0) begin
          clear_p_r   <= (cmd_r == CMD_CLEAR);
          store_p_r   <= (cmd_r == CMD_STORE) && lock_allows(cmd_r, regs_r[SL_WLOCK][7:0]);
          restore_p_r <= (cmd_r == CMD_RESTORE) && lock_allows(cmd_r, regs_r[SL_WLOCK][7:0]);
        end
        state_r    <= ST_IDLE;
        have_cmd_r <= 1'b0;
      end else if (byte_done) begin
        case (state_r)
          ST_ADDR: begin
            tx_idx_r <= 2'd0;
            if (rx_byte[7:1] != DEV_ADDR) begin
              ack_r   <= 1'b0;
              state_r <= ST_IGN;
            end else if (rx_byte[0]) begin
              // Read needs a command from before the repeated start
              ack_r   <= have_cmd_r;
              state_r <= have_cmd_r ? ST_RD : ST_IGN;
            end else begin
              ack_r   <= 1'b1;
              state_r <= ST_CMD;
            end
          end
          ST_CMD: begin
            cmd_r      <= rx_byte;
            have_cmd_r <= known_cmd;
            wr_cnt_r   <= 2'd0;
            ack_r      <= known_cmd;
            state_r    <= known_cmd ? ST_WR : ST_IGN;
          end
          ST_WR: begin
            if (wr_cnt_r == 2'd0) wr_lo_r <= rx_byte;
            if (wr_cnt_r != 2'd2) wr_cnt_r <= wr_cnt_r + 2'd1;
            ack_r         <= writable && (!last_byte || value_ok(cur_slot, wr_word));
            commit_r      <= writable && last_byte && value_ok(cur_slot, wr_word);
            commit_slot_r <= cur_slot;
            commit_data_r <= wr_word;
          end
          ST_RD: begin
            // Byte sent: step to the next one; a host refusal ends the read
            ack_r <= 1'b0;
            if (tx_idx_r != 2'd3) tx_idx_r <= tx_idx_r + 2'd1;
          end
          default: ack_r <= 1'b0;
        endcase
      end else if (scl_rise && bit_cnt_r == BIT_ACK && state_r == ST_RD) begin
        // Host not-acknowledge ends the read
        if (sda_s) state_r <= ST_IGN;
      end
    end
  end

  // ==================================================
  // Read data byte selection
  logic [15:0] rd_word;
  always_comb begin
    rd_word = (cur_slot == SL_NONE) ? 16'hffff : regs_r[cur_slot];
    tx_byte = EMPTY_BYTE;

    if (cmd_r == CMD_FEATURES) begin
      if (tx_idx_r == 2'd0) tx_byte = FEATURE_VALUE;
    end else if (cmd_r == CMD_ALERT_MASK) begin
      // Block form: count, then low and high byte
      if (tx_idx_r == 2'd0) tx_byte = BLOCK_COUNT;
      else if (tx_idx_r == 2'd1) tx_byte = rd_word[7:0];
      else if (tx_idx_r == 2'd2) tx_byte = rd_word[15:8];
    end else if (cur_slot != SL_NONE) begin
      if (tx_idx_r == 2'd0) tx_byte = rd_word[7:0];
      else if (tx_idx_r == 2'd1 && is_word(cur_slot)) tx_byte = rd_word[15:8];
    end
  end

  // ==================================================
  // Open-drain data driver, changed only while the clock is low
  always_ff @(posedge ref_clk) begin
    if (reset || start_det || stop_det) begin
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end else if (scl_fall) begin
      sda_out <= 1'b0;
      if (bit_cnt_r == BIT_ACK) sda_oe <= ack_r;
      else if (state_r == ST_RD) sda_oe <= ~tx_byte[3'(BIT_LAST - bit_cnt_r)];
      else sda_oe <= 1'b0;
    end
  end

  // ==================================================
  // Applied output voltage: margin select, trim, then ceiling
  logic [1:0]         margin;
  logic [15:0]        sel_mv, applied_mv;
  logic signed [16:0] sum_mv;
  logic               run_on;
  always_comb begin
    margin = regs_r[SL_RUN][MARGIN_LSB +: 2];
    if (margin == 2'b10) sel_mv = regs_r[SL_UPPER];
    else if (margin == 2'b01) sel_mv = regs_r[SL_LOWER];
    else sel_mv = regs_r[SL_SETPOINT];

    sum_mv = $signed({1'b0, sel_mv}) + $signed({regs_r[SL_FINE][15], regs_r[SL_FINE]});
    if (sum_mv < 0) applied_mv = 16'h0000;
    else if (sum_mv[15:0] > regs_r[SL_CEIL]) applied_mv = regs_r[SL_CEIL];
    else applied_mv = sum_mv[15:0];
  end

  // Turn-on policy: pin and command terms are required only when selected
  assign run_on = !regs_r[SL_TURN_ON][CFG_USE_BIT] ||
                  ((!regs_r[SL_TURN_ON][CFG_CMD_BIT] || regs_r[SL_RUN][RUN_ON_BIT]) &&
                   (!regs_r[SL_TURN_ON][CFG_PIN_BIT] ||
                    en_s == regs_r[SL_TURN_ON][CFG_POL_BIT]));

  // ==================================================
  // Registered outputs towards the regulator core
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg         <= '0;
      fault_clear <= 1'b0;
      otp_burn    <= 1'b0;
    end else begin
      cfg.out_on      <= run_on;
      cfg.vout_mv     <= applied_mv;
      cfg.alert_mask  <= regs_r[SL_MASK];
      cfg.slew        <= regs_r[SL_SLEW];
      cfg.divider     <= regs_r[SL_DIV];
      cfg.sw_rate     <= regs_r[SL_SWR];
      cfg.vin_start   <= regs_r[SL_VSTART];
      cfg.vin_stop    <= regs_r[SL_VSTOP];
      cfg.cs_offset   <= regs_r[SL_CSOFF];
      cfg.ov_fault    <= regs_r[SL_OVF];
      cfg.ov_warn     <= regs_r[SL_OVW];
      cfg.ov_shutdown <= regs_r[SL_OVREACT][OV_SHUT_BIT];
      // One-cycle strobes to the fault and memory logic
      fault_clear     <= clear_p_r;
      otp_burn        <= store_p_r;
    end
  end
endmodule // pmbcr_bank
`default_nettype wire

// ==== verification/pmbcr_bank_properties.sv ====
// Checker: link and output properties of the command register bank
`timescale 1ns/10ps
`default_nettype none
module pmbcr_bank_props (
  input wire logic                  ref_clk,
  input wire logic                  reset,
  input wire logic                  scl,
  input wire logic                  sda_in,
  input wire logic                  sda_out,
  input wire logic                  sda_oe,
  input wire logic                  enable_pin,
  input wire pmbcr_pkg::pmbcr_cfg_t cfg,
  input wire logic                  fault_clear,
  input wire logic                  otp_burn
);
  import pmbcr_pkg::*;
  logic [1:0] up_cnt_r;
  // ==================================================
  // Cycles since reset; cfg reads zero for the first edges, so range checks wait
  always_ff @(posedge ref_clk) begin
    if (reset) up_cnt_r <= 2'h0;
    else if (up_cnt_r != 2'h3) up_cnt_r <= up_cnt_r + 2'h1;
  end
  // ==================================================
  // Properties, all in the core clock domain
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  reset_dflt_a: assert property ($fell(reset) |-> ##[1:3] (cfg.vout_mv == 16'h03e8
    && cfg.divider == 16'he808 && cfg.ov_fault == 16'h0576)) else $error("bad reset values");
  clear_pulse_a: assert property (fault_clear |=> !fault_clear)
    else $error("fault clear wider than one cycle");
  burn_pulse_a: assert property (otp_burn |=> !otp_burn)
    else $error("store pulse wider than one cycle");
  clear_idle_a: assert property (fault_clear |-> scl && sda_in)
    else $error("fault clear inside a frame");
  pulse_apart_a: assert property (!(fault_clear && otp_burn))
    else $error("clear and store together");
  oe_on_low_a: assert property ($changed(sda_oe) |-> !scl)
    else $error("data drive changed while clock high");
  out_zero_a: assert property (sda_out == 1'b0)
    else $error("data output not low");
  divider_ok_a: assert property (up_cnt_r == 2'h3 |-> cfg.divider inside
    {16'he808, 16'he804, 16'he802, 16'he801}) else $error("illegal divider");
  slew_exp_a: assert property (up_cnt_r == 2'h3 |-> cfg.slew[15:11] inside
    {5'h00, 5'h1f, 5'h1e, 5'h1d, 5'h1c}) else $error("illegal slew exponent");
  rate_exp_a: assert property (up_cnt_r == 2'h3 |-> cfg.sw_rate[15:11] inside
    {5'h00, 5'h01}) else $error("illegal rate exponent");
  clear_c: cover property (fault_clear);
  burn_c: cover property (otp_burn);
  ack_c: cover property ($rose(sda_oe));
endmodule // pmbcr_bank_props
bind pmbcr_bank pmbcr_bank_props i_pmbcr_bank_props (.ref_clk(ref_clk), .reset(reset),
  .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .enable_pin(enable_pin),
  .cfg(cfg), .fault_clear(fault_clear), .otp_burn(otp_burn));
`default_nettype wire

// ==== verification/pmbcr_host_model.sv ====
// Host model: drives the two-wire link from the link clock, only within frames
`timescale 1ns/10ps
`default_nettype none
module pmbcr_host_model (
  input  wire logic lclk,
  input  wire logic sda,
  output logic      scl,
  output logic      host_oe
);
  // ==================================================
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    host_oe = 1'b0;
  end
  // One bit; data moves only while the clock is low, sampled one link clock into the two-clock high phase
  task automatic bit_io(input logic b, output logic s);
    @(posedge lclk) scl = 1'b0;
    @(posedge lclk) host_oe = ~b;
    @(posedge lclk);
    @(posedge lclk) scl = 1'b1;
    @(posedge lclk) s = sda;
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start();
    @(posedge lclk) scl = 1'b0;
    @(posedge lclk) host_oe = 1'b0;
    @(posedge lclk) scl = 1'b1;
    @(posedge lclk) host_oe = 1'b1;
  endtask
  // Stop, then a quiet gap so the core sees the frame end before the next start
  task automatic stop();
    @(posedge lclk) scl = 1'b0;
    @(posedge lclk) host_oe = 1'b1;
    @(posedge lclk) scl = 1'b1;
    @(posedge lclk) host_oe = 1'b0;
    repeat (3) @(posedge lclk);
  endtask
  // One byte, most significant bit first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] tx, input logic ack, output logic [7:0] rx,
                         output logic dev_ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(~ack, s);
    dev_ack = ~s;
  endtask
endmodule // pmbcr_host_model
`default_nettype wire

// ==== verification/pmbcr_bank_tb_top.sv ====
// Testbench: command register bank driven over the link by the host model
`timescale 1ns/10ps
`default_nettype none
module pmbcr_bank_tb_top;
  import pmbcr_pkg::*;
  logic        ref_clk, reset, lclk, enable_pin, scl, host_oe, sda_in, sda_out, sda_oe;
  logic        fault_clear, otp_burn, ok;
  pmbcr_cfg_t  cfg;
  logic [23:0] v;
  int          err_count = 0, comparisons = 0, clr_seen = 0, burn_seen = 0;
  // ==================================================
  // Open-drain data wire with pull-up
  assign sda_in = ~(sda_oe | host_oe);
  pmbcr_bank i_pmbcr_bank (.ref_clk(ref_clk), .reset(reset), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .enable_pin(enable_pin), .cfg(cfg),
    .fault_clear(fault_clear), .otp_burn(otp_burn));
  pmbcr_host_model i_pmbcr_host_model (.lclk(lclk), .sda(sda_in), .scl(scl), .host_oe(host_oe));
  // Core clock 50 MHz; link clock 64 ns with its own phase
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #32 lclk = ~lclk;
  end
  // Pulses are one cycle wide, so count them as they pass
  always @(posedge ref_clk) begin
    if (fault_clear === 1'b1) clr_seen++;
    if (otp_burn === 1'b1) burn_seen++;
  end
  // ==================================================
  // Shared helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Write frame; a refused byte ends it early, word data goes low byte first
  task automatic wrc(input logic [7:0] cmd, input logic [15:0] d, input int n, input logic k);
    logic [7:0] rx;
    i_pmbcr_host_model.start();
    i_pmbcr_host_model.byte_io({DEV_ADDR, 1'b0}, 1'b0, rx, ok);
    if (ok) i_pmbcr_host_model.byte_io(cmd, 1'b0, rx, ok);
    for (int i = 0; i < n; i++) if (ok) i_pmbcr_host_model.byte_io(d[8*i+:8], 1'b0, rx, ok);
    i_pmbcr_host_model.stop();
    chk($sformatf("ack %h", cmd), {15'h0, k}, {15'h0, ok});
  endtask
  // Read frame through a repeated start; the host refuses the last byte
  task automatic rd(input logic [7:0] cmd, input int n);
    logic [7:0] rx;
    logic       a;
    v = '0;
    i_pmbcr_host_model.start();
    i_pmbcr_host_model.byte_io({DEV_ADDR, 1'b0}, 1'b0, rx, a);
    i_pmbcr_host_model.byte_io(cmd, 1'b0, rx, a);
    i_pmbcr_host_model.start();
    i_pmbcr_host_model.byte_io({DEV_ADDR, 1'b1}, 1'b0, rx, a);
    for (int i = 0; i < n; i++) begin
      i_pmbcr_host_model.byte_io(8'hff, i < n - 1, rx, a);
      v[8*i+:8] = rx;
    end
    i_pmbcr_host_model.stop();
  endtask
  task automatic rdc(input logic [7:0] cmd, input int n, input logic [15:0] exp);
    rd(cmd, n);
    chk($sformatf("reg %h", cmd), exp, v[15:0]);
  endtask
  // ==================================================
  // Scenarios
  task automatic t_defaults();
    logic [7:0]  c [11] = '{8'h21, 8'h22, 8'h24, 8'h27, 8'h29, 8'h33, 8'h36, 8'h39,
                            8'h40, 8'h42, 8'h41};
    logic [15:0] e [11] = '{16'h03e8, 16'h0000, 16'h07d0, 16'he801, 16'he808, 16'h03d2,
                            16'hf80e, 16'hf000, 16'h0576, 16'h0515, 16'h0080};
    for (int i = 0; i < 11; i++) rdc(c[i], (i == 10) ? 1 : 2, e[i]);
    rd(8'h19, 1);
    chk("feature", 16'h000b, {12'h000, v[7:4]});
    wrc(8'h19, 16'h0000, 1, 1'b0);
    chk("vout", 16'h03e8, cfg.vout_mv);
  endtask
  task automatic t_setpoint();
    wrc(8'h21, 16'h0400, 2, 1'b1);
    rdc(8'h21, 2, 16'h0400);
    chk("vout", 16'h0400, cfg.vout_mv);
    wrc(8'h22, 16'h0005, 2, 1'b1);
    chk("vout trim", 16'h0405, cfg.vout_mv);
    wrc(8'h22, 16'h0000, 2, 1'b1);
    wrc(8'h21, 16'h0bb8, 2, 1'b1);
    chk("vout clamp", 16'h07d0, cfg.vout_mv);
    wrc(8'h24, 16'h05dc, 2, 1'b1);
    chk("vout ceiling", 16'h05dc, cfg.vout_mv);
    wrc(8'h24, 16'h07d0, 2, 1'b1);
    wrc(8'h21, 16'h03e8, 2, 1'b1);
  endtask
  task automatic t_margin();
    wrc(8'h25, 16'h0500, 2, 1'b1);
    wrc(8'h26, 16'h0300, 2, 1'b1);
    wrc(8'h01, 16'h00a0, 1, 1'b1);
    chk("margin high", 16'h0500, cfg.vout_mv);
    wrc(8'h01, 16'h0090, 1, 1'b1);
    chk("margin low", 16'h0300, cfg.vout_mv);
    wrc(8'h02, 16'h0018, 1, 1'b1);
    wrc(8'h01, 16'h0000, 1, 1'b1);
    chk("off", 16'h0000, {15'h0, cfg.out_on});
    rdc(8'h01, 1, 16'h0000);
    wrc(8'h01, 16'h0080, 1, 1'b1);
    chk("on nominal", 16'h83e8, {cfg.out_on, cfg.vout_mv[14:0]});
    wrc(8'h02, 16'h0016, 1, 1'b1);
  endtask
  task automatic t_policy();
    idle(1);
    enable_pin = 1'b0;
    idle(6);
    chk("pin low", 16'h0000, {15'h0, cfg.out_on});
    wrc(8'h02, 16'h0000, 1, 1'b1);
    chk("policy off", 16'h0001, {15'h0, cfg.out_on});
    wrc(8'h02, 16'h0016, 1, 1'b1);
    idle(1);
    enable_pin = 1'b1;
    idle(6);
    chk("pin high", 16'h0001, {15'h0, cfg.out_on});
  endtask
  // Each refused value follows an accepted one to the same command and must leave it standing
  task automatic t_ranges();
    logic [7:0]  c [10] = '{8'h27, 8'h27, 8'h29, 8'h29, 8'h33, 8'h33, 8'h35, 8'h39,
                            8'h40, 8'h42};
    logic [15:0] d [10] = '{16'he002, 16'hd801, 16'he804, 16'he803, 16'h09f4, 16'h1000,
                            16'hf812, 16'hf004, 16'h0500, 16'h04b0};
    logic        k [10] = '{1, 0, 1, 0, 1, 0, 1, 1, 1, 1};
    for (int i = 0; i < 10; i++) wrc(c[i], d[i], 2, k[i]);
    for (int i = 0; i < 10; i++) if (k[i]) rdc(c[i], 2, d[i]);
    chk("slew", 16'he002, cfg.slew);
    chk("divider", 16'he804, cfg.divider);
    chk("rate", 16'h09f4, cfg.sw_rate);
    chk("vin start", 16'hf812, cfg.vin_start);
    chk("cs offset", 16'hf004, cfg.cs_offset);
    chk("ov fault", 16'h0500, cfg.ov_fault);
    chk("ov warn", 16'h04b0, cfg.ov_warn);
    wrc(8'h36, 16'hf810, 2, 1'b1);
    chk("vin stop", 16'hf810, cfg.vin_stop);
    wrc(8'h41, 16'h0000, 1, 1'b1);
    chk("ov shutdown", 16'h0000, {15'h0, cfg.ov_shutdown});
  endtask
  task automatic t_lock();
    wrc(8'h10, 16'h0080, 1, 1'b1);
    wrc(8'h21, 16'h0300, 2, 1'b0);
    rdc(8'h21, 2, 16'h03e8);
    rdc(8'h10, 1, 16'h0080);
    wrc(8'h10, 16'h0000, 1, 1'b1);
    wrc(8'h21, 16'h0300, 2, 1'b1);
  endtask
  task automatic t_otp();
    wrc(8'h15, 16'h0000, 0, 1'b1);
    chk("store pulses", 16'h0001, burn_seen[15:0]);
    wrc(8'h21, 16'h0200, 2, 1'b1);
    wrc(8'h16, 16'h0000, 0, 1'b1);
    rdc(8'h21, 2, 16'h0300);
    chk("vout", 16'h0300, cfg.vout_mv);
    wrc(8'h03, 16'h0000, 0, 1'b1);
    chk("clear pulses", 16'h0001, clr_seen[15:0]);
    wrc(8'h03, 16'h0012, 1, 1'b0);
  endtask
  task automatic t_mask();
    wrc(8'h1b, 16'h1234, 2, 1'b1);
    rd(8'h1b, 3);
    chk("mask count low", 16'h3402, v[15:0]);
    chk("mask high", 16'h0012, {8'h00, v[23:16]});
    chk("mask out", 16'h1234, cfg.alert_mask);
  endtask
  // ==================================================
  // Verdict and end of run
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #1_800_000;
    err_count++;
    $display("MISMATCH watchdog expected done seen hang");
    final_report();
  end
  initial begin
    reset = 1'b1;
    enable_pin = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 reset = 1'b0;
    idle(6);
    t_defaults();
    t_setpoint();
    t_margin();
    t_policy();
    t_ranges();
    t_lock();
    t_otp();
    t_mask();
    final_report();
  end
endmodule // pmbcr_bank_tb_top
`default_nettype wire
